// *** hw/acr_pkg.sv ***
// Package of constants and types for the converter control registers
// What this block does
// - Two-bit reference code: 00 external pin, 01 analog supply, 10 reserved, 11 internal.
// - Reference and channel changes during a conversion apply only once it completes.
// - Justification bit changes the readable result at once, even mid-conversion.
// - Channel codes 0-7 single-ended inputs, 11110 bandgap, 11111 ground.
// - Codes 01000-11101 are differential pairs with gain 10x/200x or 1x.
// - Enable bit powers the converter; clearing it aborts a running conversion.
// - Writing one to start begins a conversion; free-running needs only the first.
// - First conversion after enable lasts 25 converter clocks, later ones 13.
// - Start bit reads one while converting, clears at completion; writing zero ignored.
// - With auto-trigger on, a rising edge of the chosen trigger while enabled and idle starts a conversion.
// - Completion flag sets when a conversion finishes and result registers update.
// - Completion flag clears on interrupt vector acknowledge or on writing one to it.
// - Interrupt request only when flag, local enable and global enable all set.
// - Three-bit prescaler divides system clock by 2,2,4,8,...,128.
// - Right-justified: bits 9:8 in high byte 1:0, bits 7:0 in low byte.
// - Left-justified: bits 9:2 in high byte, bits 1:0 in low byte 7:6.
// - Reading the low byte blocks result updates until the high byte is read.
// - Differential results are presented in two's-complement form.
// - Trigger source code 0 is free-running; other codes select external event flags.
// - Switching into free-running makes no trigger; cleared-to-set source switch is an edge.
// - Differential results code 0x200 most negative through 0x1ff most positive.
package acr_pkg;
  localparam logic [7:0] ACR_OFF_INPUT_SELECT = 8'h00;
  localparam logic [7:0] ACR_OFF_CONTROL_STATUS = 8'h04;
  localparam logic [7:0] ACR_OFF_RESULT_LOW = 8'h08;
  localparam logic [7:0] ACR_OFF_RESULT_HIGH = 8'h0c;
  localparam logic [7:0] ACR_OFF_TRIGGER_SELECT = 8'h10;
  localparam int ACR_ADDR_W = 8;
  localparam int ACR_REF_HI = 7;
  localparam int ACR_REF_LO = 6;
  localparam int ACR_LEFT_BIT = 5;
  localparam int ACR_CH_HI = 4;
  localparam int ACR_EN_BIT = 7;
  localparam int ACR_START_BIT = 6;
  localparam int ACR_AUTO_BIT = 5;
  localparam int ACR_FLAG_BIT = 4;
  localparam int ACR_IE_BIT = 3;
  localparam int ACR_DIV_HI = 2;
  localparam int ACR_TRIG_HI = 7;
  localparam int ACR_TRIG_LO = 5;
  localparam logic [7:0] ACR_RESET_BYTE = 8'h00;
  localparam logic [4:0] ACR_FIRST_CYCLES = 5'd25;
  localparam logic [4:0] ACR_NORMAL_CYCLES = 5'd13;
  localparam logic [2:0] ACR_TRIG_FREE = 3'h0;
  localparam logic [4:0] ACR_CH_SE_LAST = 5'h07;
  localparam logic [4:0] ACR_CH_DIFF_LAST = 5'h1d;
  localparam logic [4:0] ACR_CH_GAIN_FIRST = 5'h08;
  localparam logic [4:0] ACR_CH_GAIN_LAST = 5'h0f;
  localparam logic [4:0] ACR_CH_BANDGAP = 5'h1e;
  localparam logic [4:0] ACR_CH_GROUND = 5'h1f;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ACR_REF_EXTERNAL_PIN,
    ACR_REF_ANALOG_SUPPLY,
    ACR_REF_RESERVED,
    ACR_REF_INTERNAL
  } acr_ref_t;

  typedef enum logic [1:0] {
    ACR_MODE_SINGLE_ENDED,
    ACR_MODE_DIFFERENTIAL,
    ACR_MODE_BANDGAP,
    ACR_MODE_GROUND
  } acr_input_mode_t;

  typedef enum logic [1:0] {
    ACR_GAIN_1X,
    ACR_GAIN_10X,
    ACR_GAIN_200X
  } acr_gain_t;

  // Settings handed to the analog core, latched per conversion
  typedef struct packed {
    acr_ref_t reference;
    acr_input_mode_t mode;
    acr_gain_t gain;
    logic [4:0] channel_gain_select;
  } acr_core_cfg_t;
endpackage : acr_pkg

// *** hw/acr_top.sv ***
// Converter control registers, sequencer and AXI4-Lite slave
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module acr_top (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [acr_pkg::ACR_ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic [2:0] s_axi_awprot, // Unused protection
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [acr_pkg::ACR_ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic [2:0] s_axi_arprot, // Unused protection
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [7:1] trigger_flags, // Event flags for trigger codes 1..7
  input wire logic global_irq_enable, // Processor global interrupt enable
  input wire logic irq_vector_ack, // Pulse when the interrupt vector executes
  input wire logic [9:0] core_code, // Code from the analog core
  output logic irq_request, // Conversion complete interrupt
  output logic converter_powered, // Analog core power on
  output logic converter_clock, // Divided converter clock
  output logic core_sample, // Sample strobe to the analog core
  output logic core_capture, // Core code valid, result captured
  output acr_pkg::acr_core_cfg_t core_cfg // Latched reference and input setting
);
  import acr_pkg::*;

  typedef enum logic [1:0] {ACR_IDLE, ACR_CONVERT} acr_state_t;

  logic [7:0] input_select_q;
  logic [7:0] active_select_q;
  logic [7:0] control_q;
  logic [2:0] trigger_source_select_q;
  logic [9:0] conversion_result_q;
  logic [9:0] pending_result_q;
  logic pending_q;
  logic lock_q;
  logic first_q;
  logic [4:0] cycle_q;
  logic [6:0] div_cnt_q;
  logic conv_clk_q;
  logic trig_prev_q;
  logic [7:1] trig_s1_q;
  logic [7:1] trig_s2_q;
  logic gie_s1_q;
  logic gie_s2_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic ack_prev_q;
  acr_state_t state_q;
  logic aw_q;
  logic w_q;
  logic [ACR_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [7:0] div_limit_q;
  acr_core_cfg_t cfg_q;

  // Write decode, acted on once address and data are both held
  wire write_go = aw_q && w_q && !s_axi_bvalid;
  wire wr_byte = wstrb_q[0];
  wire [7:0] wr_data = wdata_q[7:0];
  wire wr_select = write_go && wr_byte && awaddr_q == ACR_OFF_INPUT_SELECT;
  wire wr_control = write_go && wr_byte && awaddr_q == ACR_OFF_CONTROL_STATUS;
  wire wr_trigger = write_go && wr_byte && awaddr_q == ACR_OFF_TRIGGER_SELECT;
  wire wr_mapped = awaddr_q == ACR_OFF_INPUT_SELECT || awaddr_q == ACR_OFF_CONTROL_STATUS
    || awaddr_q == ACR_OFF_TRIGGER_SELECT || awaddr_q == ACR_OFF_RESULT_LOW
    || awaddr_q == ACR_OFF_RESULT_HIGH;
  wire read_go = s_axi_arvalid && !s_axi_rvalid;
  wire rd_low = read_go && s_axi_araddr == ACR_OFF_RESULT_LOW;
  wire rd_high = read_go && s_axi_araddr == ACR_OFF_RESULT_HIGH;

  // Control bits
  wire enable = control_q[ACR_EN_BIT];
  wire busy = state_q == ACR_CONVERT;
  wire wr_enable = wr_control && wr_data[ACR_EN_BIT];
  wire wr_start = wr_control && wr_data[ACR_START_BIT];
  wire flag_clear_wr = wr_control && wr_data[ACR_FLAG_BIT];
  wire auto_on = control_q[ACR_AUTO_BIT];
  wire free_mode = trigger_source_select_q == ACR_TRIG_FREE;

  // Trigger selection; free-running returns no level so the switch makes no edge
  wire trig_level = free_mode ? 1'b0 : trig_s2_q[trigger_source_select_q];
  wire trig_edge = auto_on && trig_level && !trig_prev_q;

  // Converter clock ticks on the rising phase of the divided clock
  wire conv_tick = enable && div_cnt_q == 7'(div_limit_q - 8'd1) && !conv_clk_q;
  wire last_cycle = busy && conv_tick
    && cycle_q == 5'((first_q ? ACR_FIRST_CYCLES : ACR_NORMAL_CYCLES) - 5'd1);
  wire free_restart = last_cycle && auto_on && free_mode;
  wire launch = enable && !busy && (wr_start || trig_edge);
  wire abort = busy && !enable;

  // Result is taken on the final cycle unless the low byte lock is held and the high byte is not read in that cycle
  wire update_ok = !lock_q || rd_high;
  wire pend_commit = pending_q && !lock_q;
  wire result_write = (last_cycle && update_ok) || pend_commit;
  wire ack_pulse = ack_s2_q && !ack_prev_q;

  // Justified views built from the stored result each read
  wire left = input_select_q[ACR_LEFT_BIT];
  wire [7:0] res_low = left ? {conversion_result_q[1:0], 6'h00}
    : conversion_result_q[7:0];
  wire [7:0] res_high = left ? conversion_result_q[9:2]
    : {6'h00, conversion_result_q[9:8]};
  wire [7:0] ctrl_view = {control_q[7], busy, control_q[5:0]};
  wire rd_mapped = s_axi_araddr == ACR_OFF_INPUT_SELECT
    || s_axi_araddr == ACR_OFF_CONTROL_STATUS || s_axi_araddr == ACR_OFF_RESULT_LOW
    || s_axi_araddr == ACR_OFF_RESULT_HIGH || s_axi_araddr == ACR_OFF_TRIGGER_SELECT;
  wire [7:0] rd_byte =
    s_axi_araddr == ACR_OFF_INPUT_SELECT ? input_select_q :
    s_axi_araddr == ACR_OFF_CONTROL_STATUS ? ctrl_view :
    s_axi_araddr == ACR_OFF_RESULT_LOW ? res_low :
    s_axi_araddr == ACR_OFF_RESULT_HIGH ? res_high :
    s_axi_araddr == ACR_OFF_TRIGGER_SELECT ? {trigger_source_select_q, 5'h00} : 8'h00;

  // Decode of the latched selection for the analog core
  wire [4:0] act_ch = active_select_q[ACR_CH_HI:0];
  acr_input_mode_t mode_d;
  acr_gain_t gain_d;
  always_comb begin
    mode_d = ACR_MODE_SINGLE_ENDED;
    gain_d = ACR_GAIN_1X;
    if (act_ch == ACR_CH_BANDGAP) begin
      mode_d = ACR_MODE_BANDGAP;
    end else if (act_ch == ACR_CH_GROUND) begin
      mode_d = ACR_MODE_GROUND;
    end else if (act_ch > ACR_CH_SE_LAST && act_ch <= ACR_CH_DIFF_LAST) begin
      mode_d = ACR_MODE_DIFFERENTIAL;
      if (act_ch >= ACR_CH_GAIN_FIRST && act_ch <= ACR_CH_GAIN_LAST) begin
        gain_d = act_ch[1] ? ACR_GAIN_200X : ACR_GAIN_10X;
      end
    end
  end

  // Divisor: codes 0 and 1 give 2, then doubling to 128
  wire [2:0] div_code = control_q[ACR_DIV_HI:0];
  wire [7:0] div_limit_d = (div_code == 3'h0) ? 8'd1 : 8'(8'd1 << (div_code - 3'd1));

  // Synchronisers for pins from outside this clock's timing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_s1_q <= '0;
      trig_s2_q <= '0;
      gie_s1_q <= 1'b0;
      gie_s2_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_prev_q <= 1'b0;
    end else begin
      trig_s1_q <= trigger_flags;
      trig_s2_q <= trig_s1_q;
      gie_s1_q <= global_irq_enable;
      gie_s2_q <= gie_s1_q;
      ack_s1_q <= irq_vector_ack;
      ack_s2_q <= ack_s1_q;
      ack_prev_q <= ack_s2_q;
    end
  end

  // Registers written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_select_q <= ACR_RESET_BYTE;
      trigger_source_select_q <= 3'h0;
      control_q <= ACR_RESET_BYTE;
    end else begin
      if (wr_select) input_select_q <= wr_data;
      if (wr_trigger) trigger_source_select_q <= wr_data[ACR_TRIG_HI:ACR_TRIG_LO];
      if (wr_control) begin
        control_q[ACR_EN_BIT] <= wr_data[ACR_EN_BIT];
        control_q[ACR_AUTO_BIT] <= wr_data[ACR_AUTO_BIT];
        control_q[ACR_IE_BIT] <= wr_data[ACR_IE_BIT];
        control_q[ACR_DIV_HI:0] <= wr_data[ACR_DIV_HI:0];
      end
      control_q[ACR_START_BIT] <= 1'b0;
      // Set beats clear when completion and the clear meet
      if (result_write) begin
        control_q[ACR_FLAG_BIT] <= 1'b1;
      end else if (flag_clear_wr || ack_pulse) begin
        control_q[ACR_FLAG_BIT] <= 1'b0;
      end
    end
  end

  // Conversion sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ACR_IDLE;
      cycle_q <= 5'd0;
      first_q <= 1'b1;
      active_select_q <= ACR_RESET_BYTE;
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_level;
      if (!enable) begin
        first_q <= 1'b1;
      end
      case (state_q)
        ACR_IDLE: begin
          cycle_q <= 5'd0;
          if (launch || (wr_start && wr_enable && !busy)) begin
            state_q <= ACR_CONVERT;
            active_select_q <= input_select_q;
            if (wr_enable && !enable) first_q <= 1'b1;
          end
        end
        ACR_CONVERT: begin
          if (abort) begin
            state_q <= ACR_IDLE;
          end else if (last_cycle) begin
            first_q <= 1'b0;
            cycle_q <= 5'd0;
            active_select_q <= input_select_q;
            if (!free_restart) state_q <= ACR_IDLE;
          end else if (conv_tick) begin
            cycle_q <= cycle_q + 5'd1;
          end
        end
        default: state_q <= ACR_IDLE;
      endcase
    end
  end

  // Converter clock divider, held low while disabled
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      div_cnt_q <= 7'd0;
      conv_clk_q <= 1'b0;
      div_limit_q <= 8'd1;
    end else begin
      div_limit_q <= div_limit_d;
      if (div_cnt_q >= 7'(div_limit_q - 8'd1)) begin
        div_cnt_q <= 7'd0;
        conv_clk_q <= !conv_clk_q;
      end else begin
        div_cnt_q <= div_cnt_q + 7'd1;
      end
    end
  end

  // Result capture with low-byte read lock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conversion_result_q <= 10'h000;
      pending_result_q <= 10'h000;
      pending_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      if (rd_low) lock_q <= 1'b1;
      else if (rd_high) lock_q <= 1'b0;
      if (last_cycle && !update_ok) begin
        pending_result_q <= core_code;
        pending_q <= 1'b1;
      end else if (last_cycle) begin
        conversion_result_q <= core_code;
        pending_q <= 1'b0;
      end else if (pend_commit) begin
        conversion_result_q <= pending_result_q;
        pending_q <= 1'b0;
      end
    end
  end

  // Outputs to the core and interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_request <= 1'b0;
      converter_powered <= 1'b0;
      converter_clock <= 1'b0;
      core_sample <= 1'b0;
      core_capture <= 1'b0;
      cfg_q <= '0;
    end else begin
      irq_request <= control_q[ACR_FLAG_BIT] && control_q[ACR_IE_BIT] && gie_s2_q;
      converter_powered <= enable;
      converter_clock <= conv_clk_q;
      core_sample <= busy && conv_tick && cycle_q == 5'd0;
      core_capture <= last_cycle;
      cfg_q <= '{reference: acr_ref_t'(active_select_q[ACR_REF_HI:ACR_REF_LO]),
                 mode: mode_d, gain: gain_d, channel_gain_select: act_ch};
    end
  end
  assign core_cfg = cfg_q;

  // AXI4-Lite slave; each channel is held until both halves of a write are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= AXI_OKAY;
    end else begin
      s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[ACR_ADDR_W-1:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (write_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= read_go && !s_axi_arready;
      if (read_go && !s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= rd_mapped ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : acr_top

// *** test/acr_core_model.sv ***
// Behavioural model of the sample-and-hold and conversion core
`timescale 1ns/100ps
module acr_core_model (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic core_sample, // Sample strobe
  input wire logic core_capture, // Result taken
  input wire logic [9:0] next_code, // Code for the next conversion
  output logic [9:0] core_code // Code to the control logic
);
  logic [9:0] held_q;
  logic busy_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held_q <= 10'h000;
      busy_q <= 1'b0;
    end else if (core_sample) begin
      held_q <= next_code;
      busy_q <= 1'b1;
    end else if (core_capture) begin
      busy_q <= 1'b0;
    end
  end
  // Outside a conversion show the inverse so a stale capture cannot pass
  assign core_code = busy_q ? held_q : ~held_q;
endmodule : acr_core_model

// *** test/acr_top_bench.sv ***
// Self-checking bench for the converter control registers
`timescale 1ns/100ps
module acr_top_bench;
  import acr_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, gie, ack;
  logic awready, wready, bvalid, arready, rvalid, irq, pwr, cclk, smp, cap;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, last_resp;
  logic [7:1] trig;
  logic [9:0] next_code, code;
  acr_core_cfg_t cfg;
  acr_input_mode_t em;
  acr_gain_t eg;
  logic [4:0] mux [7] = '{5'h03, 5'h09, 5'h0a, 5'h10, 5'h1d, 5'h1e, 5'h1f};
  // Gains of the channel table for the codes above
  acr_gain_t gexp [7] = '{ACR_GAIN_1X, ACR_GAIN_10X, ACR_GAIN_200X, ACR_GAIN_1X, ACR_GAIN_1X,
    ACR_GAIN_1X, ACR_GAIN_1X};
  int num_errors = 0, total_checks = 0, cycles = 0, caps = 0, run_q = 0, len = 0;
  int c0, per, r, n;
  logic p;
  localparam logic [7:0] CS = ACR_OFF_CONTROL_STATUS;
  localparam logic [7:0] IS = ACR_OFF_INPUT_SELECT;
  localparam logic [7:0] LO = ACR_OFF_RESULT_LOW;
  localparam logic [7:0] HI = ACR_OFF_RESULT_HIGH;

  acr_top acr_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .trigger_flags(trig), .global_irq_enable(gie), .irq_vector_ack(ack), .core_code(code),
    .irq_request(irq), .converter_powered(pwr), .converter_clock(cclk),
    .core_sample(smp), .core_capture(cap), .core_cfg(cfg));
  acr_core_model acr_core_model_i (.aclk(aclk), .aresetn(aresetn), .core_sample(smp),
    .core_capture(cap), .next_code(next_code), .core_code(code));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Cycles from sample strobe to capture, and a hang limit
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    run_q <= smp ? 0 : run_q + 1;
    if (cap) begin
      caps <= caps + 1;
      len <= run_q;
    end
    if (cycles == 60000) begin
      num_errors = num_errors + 1;
      give_verdict();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    last_resp = bresp;
    bready <= 1'b0;
  endtask : wr_reg

  task rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    last_resp = rresp;
    rready <= 1'b0;
    chk(rd, {24'h000000, exp});
  endtask : rchk

  task start_conv(input logic [7:0] ctl);
    c0 = caps;
    wr_reg(CS, ctl);
  endtask : start_conv

  task wait_cap();
    repeat (8000) if (caps == c0) @(posedge aclk);
  endtask : wait_cap

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, gie, ack} = 8'h00;
    {awaddr, araddr, wdata, trig} = '0;
    wstrb = 4'h1;
    next_code = 10'h2a5;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(IS, 8'h00);
    rchk(CS, 8'h00);
    rchk(LO, 8'h00);
    rchk(HI, 8'h00);
    rchk(8'h14, 8'h00);
    chk(last_resp, AXI_SLVERR);
    wr_reg(8'h14, 8'h80);
    chk(last_resp, AXI_SLVERR);
    rchk(CS, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr_reg(CS, 8'h80 | 8'(c));
      {r, n, p} = '0;
      // A clock left high by the last setting fakes the first rise
      while (r < 3 && n < 1000) begin
        @(posedge aclk);
        n++;
        if (cclk === 1'b1 && p === 1'b0) begin
          r++;
          per = n;
          n = 0;
        end
        p = cclk;
      end
      chk(per, c < 2 ? 2 : 1 << c);
    end
    wr_reg(CS, 8'h00);
    repeat (3) @(posedge aclk);
    chk({pwr, cclk}, 2'b00);
    wr_reg(IS, 8'h05);
    chk(last_resp, AXI_OKAY);
    start_conv(8'hc0);
    wait_cap();
    chk((len + 3) / 2, 25);
    rchk(LO, 8'ha5);
    rchk(HI, 8'h02);
    rchk(CS, 8'h90);
    wr_reg(IS, 8'h25);
    start_conv(8'hd0);
    rchk(CS, 8'hc0);
    wr_reg(CS, 8'h80);
    rchk(CS, 8'hc0);
    wait_cap();
    chk((len + 3) / 2, 13);
    next_code = 10'h15a;
    rchk(LO, 8'h40);
    start_conv(8'hd0);
    wait_cap();
    rchk(HI, 8'ha9);
    rchk(LO, 8'h80);
    rchk(HI, 8'h56);
    wr_reg(IS, 8'h05);
    rchk(LO, 8'h5a);
    rchk(HI, 8'h01);
    wr_reg(IS, 8'h03);
    start_conv(8'hd0);
    wr_reg(IS, 8'h04);
    // The new selection waits for the running conversion to finish
    chk(cfg.channel_gain_select, 5'h03);
    wait_cap();
    chk(cfg.channel_gain_select, 5'h04);
    start_conv(8'hd0);
    wait_cap();
    chk(cfg.channel_gain_select, 5'h04);
    next_code = 10'h200;
    for (int i = 0; i < 7; i++) begin
      wr_reg(IS, {i[1:0], 1'b0, mux[i]});
      start_conv(8'hd0);
      wait_cap();
      em = mux[i] < 5'h08 ? ACR_MODE_SINGLE_ENDED : mux[i] == ACR_CH_BANDGAP ?
        ACR_MODE_BANDGAP : mux[i] == ACR_CH_GROUND ? ACR_MODE_GROUND : ACR_MODE_DIFFERENTIAL;
      eg = gexp[i];
      chk(cfg.reference, i[1:0]);
      chk(cfg.mode, em);
      if (em == ACR_MODE_DIFFERENTIAL) chk(cfg.gain, eg);
    end
    rchk(LO, 8'h00);
    rchk(HI, 8'h02);
    gie <= 1'b1;
    start_conv(8'hd8);
    wait_cap();
    repeat (4) @(posedge aclk);
    chk(irq, 1'b1);
    wr_reg(CS, 8'h98);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    start_conv(8'hc8);
    wait_cap();
    repeat (4) @(posedge aclk);
    ack <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(irq, 1'b0);
    ack <= 1'b0;
    start_conv(8'hc8);
    wait_cap();
    gie <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(irq, 1'b0);
    wr_reg(CS, 8'h10);
    start_conv(8'hc0);
    repeat (10) @(posedge aclk);
    wr_reg(CS, 8'h00);
    repeat (80) @(posedge aclk);
    chk(caps, c0);
    rchk(CS, 8'h00);
    wr_reg(ACR_OFF_TRIGGER_SELECT, 8'h20);
    start_conv(8'hb0);
    trig[1] <= 1'b1;
    wait_cap();
    chk(caps, c0 + 1);
    trig[1] <= 1'b0;
    trig[3] <= 1'b1;
    c0 = caps;
    // Moving from a low source to a high one counts as a rising edge
    wr_reg(ACR_OFF_TRIGGER_SELECT, 8'h60);
    wait_cap();
    chk(caps, c0 + 1);
    trig[3] <= 1'b0;
    wr_reg(ACR_OFF_TRIGGER_SELECT, 8'h00);
    c0 = caps;
    repeat (60) @(posedge aclk);
    chk(caps, c0);
    start_conv(8'hf0);
    wait_cap();
    c0 = caps;
    wait_cap();
    chk(caps, c0 + 1);
    wr_reg(CS, 8'h00);
    give_verdict();
  end
endmodule : acr_top_bench

// *** test/acr_top_sva.sv ***
// Port-level assertions for the converter control registers
`timescale 1ns/100ps
module acr_top_sva (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic global_irq_enable, // Processor global enable
  input wire logic irq_request, // Conversion complete interrupt
  input wire logic converter_powered, // Core power
  input wire logic converter_clock, // Divided clock
  input wire logic core_sample, // Sample strobe
  input wire logic core_capture, // Result captured
  input wire acr_pkg::acr_core_cfg_t core_cfg // Latched input setting
);
  import acr_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [2:0] gie_low_q;
  logic [7:0] since_q;
  // Saturating counts keep the checks bounded for slow dividers
  always_ff @(posedge aclk) begin
    if (!aresetn || global_irq_enable) gie_low_q <= 3'h0;
    else if (gie_low_q != 3'h7) gie_low_q <= gie_low_q + 3'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || core_sample) since_q <= 8'h00;
    else if (since_q != 8'hff) since_q <= since_q + 8'h01;
  end
  property p_irq_needs_global;
    gie_low_q == 3'h7 |-> !irq_request;
  endproperty
  property p_sample_pulse;
    core_sample |=> !core_sample;
  endproperty
  property p_capture_pulse;
    core_capture |=> !core_capture;
  endproperty
  property p_conv_length;
    core_capture |-> since_q >= 8'd22;
  endproperty
  property p_off_clock_low;
    !converter_powered [*2] |-> !converter_clock;
  endproperty
  property p_off_no_sample;
    !converter_powered ##1 !converter_powered |-> !core_sample;
  endproperty
  property p_cfg_held;
    core_sample ##3 1'b1 |-> $stable(core_cfg) [*8];
  endproperty
  property p_capture_while_on;
    core_capture |-> $past(converter_powered);
  endproperty
  a_irq_needs_global: assert property (p_irq_needs_global) else $error("irq without global enable");
  a_sample_pulse: assert property (p_sample_pulse) else $error("sample strobe too long");
  a_capture_pulse: assert property (p_capture_pulse) else $error("capture strobe too long");
  a_conv_length: assert property (p_conv_length) else $error("conversion too short");
  a_off_clock_low: assert property (p_off_clock_low) else $error("clock runs while off");
  a_off_no_sample: assert property (p_off_no_sample) else $error("sample while off");
  a_cfg_held: assert property (p_cfg_held) else $error("setting changed mid conversion");
  a_capture_while_on: assert property (p_capture_while_on) else $error("capture after off");
  c_capture: cover property (core_capture);
  c_irq: cover property ($rose(irq_request));
  c_abort: cover property ($fell(converter_powered));
endmodule : acr_top_sva

bind acr_top acr_top_sva acr_top_sva_i (.aclk(aclk), .aresetn(aresetn),
  .global_irq_enable(global_irq_enable), .irq_request(irq_request),
  .converter_powered(converter_powered), .converter_clock(converter_clock),
  .core_sample(core_sample), .core_capture(core_capture), .core_cfg(core_cfg));
